// file: hw/qbio_pkg.sv
/*
  qbio_pkg: constants and carrier types for the quad byte I/O port.
  assumes: included before the port module; 8-bit special function register space.
*/
package qbio_pkg;
  localparam int QBIO_PORTS = 4;
  localparam int QBIO_WIDTH = 8;
  localparam logic [7:0] QBIO_PORT_ZERO_ADDR = 8'h80;
  localparam logic [7:0] QBIO_PORT_ONE_ADDR = 8'h90;
  localparam logic [7:0] QBIO_PORT_TWO_ADDR = 8'hA0;
  localparam logic [7:0] QBIO_PORT_THREE_ADDR = 8'hB0;
  localparam logic [7:0] QBIO_DATA_RESET = 8'hFF;
  localparam logic [7:0] QBIO_READ_NONE = 8'h00;

  typedef struct packed {
    logic [7:0] addr;
    logic wrEn;
    logic rdEn;
    logic rmw;
    logic [7:0] wrData;
  } qbio_sfr_s;
endpackage : qbio_pkg

// file: hw/qbio_port.sv
/*
  qbio_port: four 8-bit general purpose ports behind special function registers.
  assumes: core drives one sfr access per cycle on ref_clk; pins are asynchronous.
*/
`timescale 1ns/1ps

// Summary of operation
// - four 8-bit ports at 0x80, 0x90, 0xA0, 0xB0 each own register
// - read-modify-write reads return the output data register, not pins
// - other reads of a mapped port return synchronised pin levels; unmapped reads return 0x00
// - separate input and output pins, no tri-state anywhere
module qbio_port
  import qbio_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire qbio_sfr_s sfrReq,
  output logic [7:0] sfrRdData,
  output logic sfrRdHit,
  input wire logic [31:0] portPinIn,
  output logic [31:0] portPinOut
);

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  logic [3:0] portSel;
  assign portSel[0] = (sfrReq.addr == QBIO_PORT_ZERO_ADDR);
  assign portSel[1] = (sfrReq.addr == QBIO_PORT_ONE_ADDR);
  assign portSel[2] = (sfrReq.addr == QBIO_PORT_TWO_ADDR);
  assign portSel[3] = (sfrReq.addr == QBIO_PORT_THREE_ADDR);
  wire anyHit = |portSel;

  // ------------------------------------------------------------
  // pin synchroniser
  // ------------------------------------------------------------
  // two flops; pin levels read back lag the pins by two cycles
  logic [31:0] pinMeta;
  logic [31:0] pinSync;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      // idle level of the pulled-up pins, so no false low follows reset
      pinMeta <= {QBIO_PORTS{QBIO_DATA_RESET}};
      pinSync <= {QBIO_PORTS{QBIO_DATA_RESET}};
    end else begin
      pinMeta <= portPinIn;
      pinSync <= pinMeta;
    end
  end

  // ------------------------------------------------------------
  // data registers
  // ------------------------------------------------------------
  logic [7:0] portData [QBIO_PORTS];
  logic [7:0] next_rdData;
  logic next_rdHit;

  genvar g;
  generate
    for (g = 0; g < QBIO_PORTS; g++) begin : gPort
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          portData[g] <= QBIO_DATA_RESET;
        end else if (sfrReq.wrEn && portSel[g]) begin
          portData[g] <= sfrReq.wrData;
        end
      end
      assign portPinOut[g*8 +: 8] = portData[g];
    end
  endgenerate

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // per-port readback byte, masked by its select
  logic [7:0] portReadback [QBIO_PORTS];
  logic [7:0] portReadMasked [QBIO_PORTS];
  genvar r;
  generate
    for (r = 0; r < QBIO_PORTS; r++) begin : gRead
      assign portReadback[r] = sfrReq.rmw ? portData[r] : pinSync[r*QBIO_WIDTH +: QBIO_WIDTH];
      assign portReadMasked[r] = portReadback[r] & {QBIO_WIDTH{portSel[r]}};
    end
  endgenerate
  // decode is one-hot, so or-ing the masked bytes is a mux without priority
  assign next_rdData = portReadMasked[0] | portReadMasked[1] | portReadMasked[2] | portReadMasked[3];
  assign next_rdHit = sfrReq.rdEn && anyHit;

  // registered read data: answer one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sfrRdData <= QBIO_READ_NONE;
      sfrRdHit <= 1'b0;
    end else begin
      sfrRdData <= sfrReq.rdEn ? next_rdData : QBIO_READ_NONE;
      sfrRdHit <= next_rdHit;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // checker-side address map, built from the constants rather than the decode
  wire chkMapped = (sfrReq.addr == QBIO_PORT_ZERO_ADDR) || (sfrReq.addr == QBIO_PORT_ONE_ADDR) ||
      (sfrReq.addr == QBIO_PORT_TWO_ADDR) || (sfrReq.addr == QBIO_PORT_THREE_ADDR);
  wire chkRmwRead = sfrReq.rdEn && sfrReq.rmw;
  wire chkPinRead = sfrReq.rdEn && !sfrReq.rmw;

  AST_WRITE_PORT0: assert property (sfrReq.wrEn && sfrReq.addr == QBIO_PORT_ZERO_ADDR
      |=> portPinOut[7:0] == $past(sfrReq.wrData))
    else $error("port zero write lost");

  AST_WRITE_PORT1: assert property (sfrReq.wrEn && sfrReq.addr == QBIO_PORT_ONE_ADDR
      |=> portPinOut[15:8] == $past(sfrReq.wrData))
    else $error("port one write lost");

  AST_WRITE_PORT2: assert property (sfrReq.wrEn && sfrReq.addr == QBIO_PORT_TWO_ADDR
      |=> portPinOut[23:16] == $past(sfrReq.wrData))
    else $error("port two write lost");

  AST_WRITE_PORT3: assert property (sfrReq.wrEn && sfrReq.addr == QBIO_PORT_THREE_ADDR
      |=> portPinOut[31:24] == $past(sfrReq.wrData))
    else $error("port three write lost");

  AST_OWN_REG: assert property (sfrReq.wrEn && sfrReq.addr == QBIO_PORT_ZERO_ADDR
      |=> $stable(portPinOut[31:8]))
    else $error("port zero write disturbed another port");

  AST_HOLD: assert property (!sfrReq.wrEn
      |=> $stable(portPinOut))
    else $error("outputs changed without write");

  AST_MISS_WRITE: assert property (sfrReq.wrEn && !chkMapped
      |=> $stable(portPinOut))
    else $error("unmapped write changed outputs");

  AST_RESET_VALUE: assert property (disable iff (1'b0) !reset_n
      |=> portPinOut == {QBIO_PORTS{QBIO_DATA_RESET}} && !sfrRdHit && sfrRdData == QBIO_READ_NONE)
    else $error("reset values wrong");

  AST_RMW_READ0: assert property (chkRmwRead && sfrReq.addr == QBIO_PORT_ZERO_ADDR
      |=> sfrRdHit && sfrRdData == $past(portPinOut[7:0]))
    else $error("rmw read of port zero did not return register");

  AST_RMW_READ1: assert property (chkRmwRead && sfrReq.addr == QBIO_PORT_ONE_ADDR
      |=> sfrRdHit && sfrRdData == $past(portPinOut[15:8]))
    else $error("rmw read of port one did not return register");

  AST_RMW_READ: assert property (chkRmwRead && sfrReq.addr == QBIO_PORT_TWO_ADDR
      |=> sfrRdHit && sfrRdData == $past(portPinOut[23:16]))
    else $error("rmw read did not return register");

  AST_RMW_READ3: assert property (chkRmwRead && sfrReq.addr == QBIO_PORT_THREE_ADDR
      |=> sfrRdHit && sfrRdData == $past(portPinOut[31:24]))
    else $error("rmw read of port three did not return register");

  AST_RMW_OLD: assert property (chkRmwRead && sfrReq.wrEn && sfrReq.addr == QBIO_PORT_ONE_ADDR
      |=> sfrRdData == $past(portPinOut[15:8]) && portPinOut[15:8] == $past(sfrReq.wrData))
    else $error("simultaneous write and rmw read mixed up");

  AST_PIN_READ0: assert property (chkPinRead && sfrReq.addr == QBIO_PORT_ZERO_ADDR
      |=> sfrRdHit && sfrRdData == $past(pinSync[7:0]))
    else $error("plain read of port zero did not return pins");

  AST_PIN_READ: assert property (chkPinRead && sfrReq.addr == QBIO_PORT_ONE_ADDR
      |=> sfrRdHit && sfrRdData == $past(pinSync[15:8]))
    else $error("plain read did not return pins");

  AST_PIN_READ2: assert property (chkPinRead && sfrReq.addr == QBIO_PORT_TWO_ADDR
      |=> sfrRdHit && sfrRdData == $past(pinSync[23:16]))
    else $error("plain read of port two did not return pins");

  AST_PIN_READ3: assert property (chkPinRead && sfrReq.addr == QBIO_PORT_THREE_ADDR
      |=> sfrRdHit && sfrRdData == $past(pinSync[31:24]))
    else $error("plain read of port three did not return pins");

  AST_SYNC_DELAY: assert property (##2 1'b1
      |-> pinSync == $past(portPinIn, 2))
    else $error("pin sync not two stages");

  AST_MISS: assert property (sfrReq.rdEn && !chkMapped
      |=> !sfrRdHit && sfrRdData == QBIO_READ_NONE)
    else $error("unmapped address answered");

  AST_HIT: assert property (sfrReq.rdEn && chkMapped
      |=> sfrRdHit)
    else $error("mapped read not answered");

  AST_NO_READ: assert property (!sfrReq.rdEn
      |=> !sfrRdHit && sfrRdData == QBIO_READ_NONE)
    else $error("read hit without request");

  // ------------------------------------------------------------
  // coverage
  // ------------------------------------------------------------
  COV_WRITE: cover property (sfrReq.wrEn && anyHit);
  COV_RMW: cover property (sfrReq.rdEn && sfrReq.rmw && anyHit);
  COV_PIN: cover property (sfrReq.rdEn && !sfrReq.rmw && anyHit);
  COV_WR_THEN_RMW: cover property (sfrReq.wrEn && portSel[1] ##1 sfrReq.rdEn && sfrReq.rmw && portSel[1]);
  COV_MISS: cover property (sfrReq.rdEn && !chkMapped);

endmodule : qbio_port

// file: sim/qbio_pins_model.sv
/* external pin circuitry: pull-ups, plus a driver that can pull pins low.
   assumes the port drives its output pins open-drain, so a high output leaves the pin to the pull-up. */
`timescale 1ns/1ps
module qbio_pins_model (
  input wire logic [31:0] portPinOut,
  input wire logic [31:0] pullLow_n,
  output logic [31:0] portPinIn
);
  // in and out pins kept apart; pull-ups wire-and with the pull-downs
  assign portPinIn = portPinOut & pullLow_n;
endmodule : qbio_pins_model

// file: sim/tb_qbio_port.sv
/* self-checking bench for qbio_port.
   assumes the 1-cycle read latency and 2-flop pin sync. */
`timescale 1ns/1ps
module tb_qbio_port;
  import qbio_pkg::*;
  logic ref_clk = 0, reset_n = 0, sfrRdHit;
  qbio_sfr_s sfrReq = '0;
  logic [7:0] sfrRdData, d, ad [4];
  logic [31:0] portPinIn, portPinOut, pullLow_n = '1, shadow = '1, seed = 32'hDB6BF3A3;
  int fails = 0, samples_checked = 0, p;
  always #2 ref_clk = ~ref_clk;
  qbio_port u_qbio_port (.ref_clk(ref_clk), .reset_n(reset_n), .sfrReq(sfrReq), .sfrRdData(sfrRdData),
    .sfrRdHit(sfrRdHit), .portPinIn(portPinIn), .portPinOut(portPinOut));
  qbio_pins_model u_qbio_pins_model (.portPinOut(portPinOut), .pullLow_n(pullLow_n), .portPinIn(portPinIn));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // expected read answer: rmw sees the register, any other read the pin levels
  function automatic logic [8:0] exp_rd(input logic m, input logic [7:0] regVal, input logic [7:0] pins);
    return {1'b1, m ? regVal : pins};
  endfunction : exp_rd
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic acc(input logic [7:0] a, input logic w, input logic r, input logic m, input logic [7:0] wd);
    @(negedge ref_clk) sfrReq <= '{a, w, r, m, wd};
    @(negedge ref_clk) sfrReq <= '0;
  endtask : acc
  task automatic final_report;
    $display("checked %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  initial begin
    ad = '{QBIO_PORT_ZERO_ADDR, QBIO_PORT_ONE_ADDR, QBIO_PORT_TWO_ADDR, QBIO_PORT_THREE_ADDR};
    repeat (8) @(negedge ref_clk);
    reset_n <= 1;
    @(negedge ref_clk);
    check(portPinOut, {QBIO_PORTS{QBIO_DATA_RESET}});
    acc(ad[3], 0, 1, 1, 8'h00);
    check({sfrRdHit, sfrRdData}, exp_rd(1'b1, QBIO_DATA_RESET, 8'h00));
    $display("reset test done");
    for (int i = 0; i < 24; i++) begin
      p = i % 4;
      seed = xs(seed);
      d = (i < 4) ? 8'h00 : seed[7:0];
      acc(ad[p], 1, 0, 0, d);
      shadow[8*p+:8] = d;
      check(portPinOut, shadow);
      acc(ad[p], 0, 1, 1, 8'h00);
      check({sfrRdHit, sfrRdData}, exp_rd(1'b1, d, 8'h00));
      pullLow_n[8*p+:8] <= seed[15:8];
      repeat (3) @(negedge ref_clk);
      acc(ad[p], 0, 1, 0, 8'h00);
      check({sfrRdHit, sfrRdData}, exp_rd(1'b0, d, d & seed[15:8]));
    end
    $display("random port test done");
    acc(ad[1], 1, 1, 1, ~shadow[15:8]);
    check({sfrRdHit, sfrRdData}, exp_rd(1'b1, shadow[15:8], 8'h00));
    shadow[15:8] = ~shadow[15:8];
    acc(8'h91, 1, 1, 0, 8'h3C);
    check({sfrRdHit, sfrRdData}, 9'h000);
    check(portPinOut, shadow);
    $display("corner test done");
    reset_n <= 0;
    repeat (2) @(negedge ref_clk);
    reset_n <= 1;
    shadow = '1;
    @(negedge ref_clk);
    check(portPinOut, shadow);
    check({sfrRdHit, sfrRdData}, 9'h000);
    repeat (3) @(negedge ref_clk);
    acc(ad[0], 0, 1, 0, 8'h00);
    check({sfrRdHit, sfrRdData}, exp_rd(1'b0, 8'hFF, 8'hFF & pullLow_n[7:0]));
    $display("mid-run reset test done");
    final_report();
  end
endmodule : tb_qbio_port
